// ### inc/msa_pkg.sv
// Purpose: Shared constants and carriers for the shared bus arbiter
// Assumes: Six request lines, identifiers 1 to 6
// Notes: Byte addresses on the register port, one 32-bit word each
package msa_pkg;
    localparam int NUM_LINES = 6;
    localparam int ON_MODULE_LINES = 4;
    localparam logic [2:0] INIT_MASTER = 3'h0;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 32;
    localparam int MSG_REGS = 8;
    localparam int TENURE_W = 16;
    localparam logic [TENURE_W-1:0] TENURE_RESET = 16'h00FF;
    localparam int TGT_HI = 8;
    localparam int TGT_LO = 6;
    localparam logic [2:0] TGT_BCAST = 3'h7;
    localparam int IDX_HI = 5;
    localparam int IDX_LO = 2;
    localparam logic [3:0] IDX_CTRL = 4'h0;
    localparam logic [3:0] IDX_TENURE = 4'h1;
    localparam logic [3:0] IDX_STATUS = 4'h2;
    localparam logic [3:0] IDX_VECTOR = 4'h3;
    localparam int IDX_MSG_BIT = 3;
    localparam int CTRL_TENURE_EN = 0;
    localparam int CTRL_CORE_FIRST = 1;
    localparam int ST_MASTER_LO = 0;
    localparam int ST_GRANT = 3;
    localparam int ST_HANDOVER = 4;
    localparam int ST_VEC_PEND = 5;
    localparam int ST_OWN_ID_LO = 8;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [1:0] PH_ISSUE = 2'h1;

    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
    } msa_avm_req_t;

    typedef struct packed {
        logic core_req;
        logic dma_req;
        logic lock;
    } msa_local_req_t;

    typedef enum logic [1:0] {
        ARB_SETTLED = 2'b01,
        ARB_HANDOVER = 2'b10
    } msa_arb_state_t;
endpackage

// ### test/msa_arbiter_top_properties.sv
// Purpose: Port-level timing checks on one arbiter copy
// Assumes: Request lines resolved with pull-ups before the inputs
// Notes: Winner is recomputed here from the observed lines
`timescale 1ns/10ps
`default_nettype none
module msa_arbiter_checker #(
    parameter int LINES = 6,
    parameter int TENURE_BITS = 16
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [2:0] own_id_in,
    input wire logic rotate_priority_select_in,
    input wire logic [LINES-1:0] bus_request_n_in,
    input wire msa_pkg::msa_avm_req_t avm_req_in,
    input wire logic [LINES-1:0] bus_request_n_out,
    input wire logic [LINES-1:0] bus_request_oe_out,
    input wire logic bus_grant_out,
    input wire logic [2:0] master_id_out,
    input wire logic handover_out,
    input wire logic avm_waitrequest_out
);
    import msa_pkg::*;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic [LINES-1:0] m_mask, o_mask;
    logic [2:0] win;
    logic m_rel, trans;
    assign m_mask = LINES'(1) << (master_id_out - 3'h1);
    assign o_mask = LINES'(1) << (own_id_in - 3'h1);
    assign m_rel = |(bus_request_n_in & m_mask);
    assign trans = !handover_out && m_rel && !(&(bus_request_n_in | m_mask));
    // Lowest search distance wins, so scan downwards
    always_comb begin
        int s, k;
        s = rotate_priority_select_in ? int'(master_id_out) % LINES : 0;
        k = 0;
        win = 3'h0;
        for (int i = LINES - 1; i >= 0; i--) begin
            k = (s + i) % LINES;
            if (!bus_request_n_in[k]) win = 3'(k + 1);
        end
    end
    sequence s_pulse;
        handover_out ##1 !handover_out;
    endsequence
    sequence s_answer;
        avm_waitrequest_out ##1 !avm_waitrequest_out;
    endsequence
    AST_ONE_CYCLE: assert property (
        $rose(handover_out) |-> s_pulse)
        else $error("handover lasted more than one cycle");
    AST_TRANSITION: assert property (
        trans |=> handover_out && master_id_out == $past(win))
        else $error("wrong or missing bus transition");
    AST_KEEP: assert property (
        !handover_out && !m_rel |=> $stable(master_id_out) && !handover_out)
        else $error("master lost bus while requesting");
    AST_LONE: assert property (
        !handover_out && &bus_request_n_in |=>
        $stable(master_id_out) && !handover_out)
        else $error("lone release changed master");
    AST_GRANT: assert property (
        handover_out && master_id_out == own_id_in |=> bus_grant_out)
        else $error("grant missing after handover");
    AST_NO_GRANT: assert property (
        bus_grant_out |-> master_id_out == own_id_in && !handover_out)
        else $error("grant without mastership");
    AST_OWN_LINE: assert property (
        !$past(rst_in) |-> bus_request_oe_out == o_mask &&
        (bus_request_n_out | o_mask) == '1)
        else $error("drives a line other than its own");
    AST_ANSWER: assert property (
        $rose(avm_req_in.read | avm_req_in.write) |=> s_answer)
        else $error("register answer not two cycles after request");
endmodule
`default_nettype wire

// ### test/msa_peer_model.sv
// Purpose: Peer processors sharing the request lines
// Assumes: Each peer pulls only its own line, lines have pull-ups
// Notes: Registered, so peers react one edge after being told
`timescale 1ns/10ps
`default_nettype none
module msa_peer_model (
    input wire logic clk_in,
    input wire logic [2:0] own_id_in,
    input wire logic [5:0] want_in,
    output logic [5:0] line_n_out
);
    import msa_pkg::*;
    // Our own line is left released so only the device drives it
    always_ff @(posedge clk_in) begin
        line_n_out <= ~want_in |
            (6'h01 << (own_id_in - 3'h1));
    end
endmodule
`default_nettype wire

// ### test/multiproc_shared_bus_arbiter_tb.sv
// Purpose: Self-checking bench for one arbiter copy
// Assumes: Own id 3, peers on the other five lines
// Notes: A peer's core-first wish is a separate pull-down on that line
`timescale 1ns/10ps
`default_nettype none
module multiproc_shared_bus_arbiter_tb;
    import msa_pkg::*;
    logic clk_in, rst_in, rot, ack, cf_n, cf_oe, grant, ho, irq, wr;
    logic cf_pn;
    logic [5:0] want, peer_n, rq_n, rq_oe, bus_n;
    logic [2:0] mid;
    logic [31:0] va, rd;
    msa_local_req_t loc;
    msa_avm_req_t req;
    int failures, tests_run;
    // Open-drain resolution: released lines float high
    assign bus_n = peer_n & (~rq_oe | rq_n);
    msa_peer_model msa_peer_model_inst (.clk_in(clk_in), .own_id_in(3'h3),
        .want_in(want), .line_n_out(peer_n));
    msa_arbiter_top msa_arbiter_top_inst (.clk_in(clk_in), .rst_in(rst_in),
        .own_id_in(3'h3), .rotate_priority_select_in(rot),
        .bus_request_n_in(bus_n),
        .core_first_access_n_in(cf_pn & (~cf_oe | cf_n)),
        .local_req_in(loc), .vector_irq_ack_in(ack), .avm_req_in(req),
        .bus_request_n_out(rq_n), .bus_request_oe_out(rq_oe),
        .core_first_access_n_out(cf_n), .core_first_access_oe_out(cf_oe),
        .bus_grant_out(grant), .master_id_out(mid), .handover_out(ho),
        .vector_irq_out(irq), .vector_irq_address_out(va),
        .avm_readdata_out(rd), .avm_waitrequest_out(wr));
    task automatic tally_and_finish();
        if (failures == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [8:0] ad(input logic [2:0] id,
        input logic [3:0] ix);
        return {id, ix, 2'h0};
    endfunction
    task automatic bus(input logic w, input logic [8:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_in);
        req <= '{read: !w, write: w, address: a, writedata: d};
        @(posedge clk_in);
        while (wr !== 1'b0) begin
            n++;
            if (n > 20) begin
                failures++;
                tally_and_finish();
            end
            @(posedge clk_in);
        end
        q = rd;
        req <= '0;
    endtask
    task automatic wait_ho();
        repeat (20) begin
            @(negedge clk_in);
            if (ho === 1'b1) return;
        end
        failures++;
        tally_and_finish();
    endtask
    task automatic t_fixed();
        @(posedge clk_in);
        want <= 6'h03;
        loc.dma_req <= 1'b1;
        repeat (6) @(negedge clk_in);
        chk(32'(mid), 32'h1);
        @(posedge clk_in);
        want <= 6'h02;
        wait_ho();
        chk(32'(mid), 32'h2);
        @(posedge clk_in);
        want <= 6'h00;
        wait_ho();
        chk(32'(mid), 32'h3);
        @(negedge clk_in);
        chk(32'({ho, grant}), 32'h1);
    endtask
    task automatic t_rotate();
        @(posedge clk_in);
        rot <= 1'b1;
        want <= 6'h11;
        repeat (4) @(posedge clk_in);
        loc.dma_req <= 1'b0;
        wait_ho();
        chk(32'(mid), 32'h5);
        @(negedge clk_in);
        chk(32'(grant), 32'h0);
        @(posedge clk_in);
        want <= 6'h00;
        repeat (6) begin
            @(negedge clk_in);
            chk(32'({ho, mid}), 32'h5);
        end
    endtask
    task automatic t_regs();
        logic [31:0] q;
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, ad(3'h3, 4'(8 + i)), 32'hA500 + 32'(i), q);
        end
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, ad(3'h3, 4'(8 + i)), 32'h0, q);
            chk(q, 32'hA500 + 32'(i));
        end
        bus(1'b1, ad(3'h7, 4'h8), 32'h5A5A_0001, q);
        bus(1'b0, ad(3'h3, 4'h8), 32'h0, q);
        chk(q, 32'h5A5A_0001);
        bus(1'b1, ad(3'h2, 4'h9), 32'hDEAD_0000, q);
        bus(1'b0, ad(3'h3, 4'h9), 32'h0, q);
        chk(q, 32'hA501);
        bus(1'b0, ad(3'h2, 4'h9), 32'h0, q);
        chk(q, 32'h0);
        bus(1'b0, ad(3'h3, 4'h4), 32'h0, q);
        chk(q, 32'h0);
        bus(1'b0, ad(3'h3, IDX_TENURE), 32'h0, q);
        chk(q, 32'h0000_00FF);
        bus(1'b0, ad(3'h3, IDX_STATUS), 32'h0, q);
        chk(q, 32'h0000_0305);
    endtask
    task automatic t_vector();
        logic [31:0] q;
        bus(1'b1, ad(3'h3, IDX_VECTOR), 32'h0000_1234, q);
        repeat (2) @(negedge clk_in);
        chk({irq, va[30:0]}, 32'h8000_1234);
        @(posedge clk_in);
        ack <= 1'b1;
        @(posedge clk_in);
        ack <= 1'b0;
        repeat (2) @(negedge clk_in);
        chk(32'(irq), 32'h0);
    endtask
    // Lock must outlast an expired tenure; then the cap and a peer's
    // core-first wish each have to push us off the bus on their own
    task automatic t_cap();
        logic [31:0] q;
        bus(1'b1, ad(3'h3, IDX_CTRL), 32'h3, q);
        bus(1'b1, ad(3'h3, IDX_TENURE), 32'h4, q);
        @(posedge clk_in);
        want <= 6'h10;
        loc.core_req <= 1'b1;
        repeat (3) @(negedge clk_in);
        chk(32'({cf_oe, cf_n, rq_n}), 32'hBB);
        @(posedge clk_in);
        want <= 6'h00;
        wait_ho();
        chk(32'(mid), 32'h3);
        @(posedge clk_in);
        want <= 6'h01;
        loc.lock <= 1'b1;
        repeat (10) @(negedge clk_in);
        chk(32'({grant, mid}), 32'hB);
        @(posedge clk_in);
        loc.lock <= 1'b0;
        wait_ho();
        chk(32'(mid), 32'h1);
        bus(1'b1, ad(3'h3, IDX_CTRL), 32'h2, q);
        @(posedge clk_in);
        want <= 6'h00;
        wait_ho();
        chk(32'(mid), 32'h3);
        @(posedge clk_in);
        want <= 6'h01;
        cf_pn <= 1'b0;
        loc <= '{core_req: 1'b0, dma_req: 1'b1, lock: 1'b0};
        wait_ho();
        chk(32'(mid), 32'h1);
        @(posedge clk_in);
        cf_pn <= 1'b1;
        want <= 6'h00;
        loc <= '0;
    endtask
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    initial begin
        {rst_in, rot, ack, want, loc, req} = '0;
        cf_pn = 1'b1;
        rst_in = 1'b1;
        failures = 0;
        tests_run = 0;
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        @(negedge clk_in);
        chk(32'({grant, ho, wr, mid}), 32'h09);
        t_fixed();
        t_rotate();
        t_regs();
        t_vector();
        t_cap();
        tally_and_finish();
    end
endmodule
bind msa_arbiter_top msa_arbiter_checker #(.LINES(LINES),
    .TENURE_BITS(TENURE_BITS)) msa_arbiter_checker_inst (.clk_in(clk_in),
    .rst_in(rst_in), .own_id_in(own_id_in),
    .rotate_priority_select_in(rotate_priority_select_in),
    .bus_request_n_in(bus_request_n_in), .avm_req_in(avm_req_in),
    .bus_request_n_out(bus_request_n_out),
    .bus_request_oe_out(bus_request_oe_out), .bus_grant_out(bus_grant_out),
    .master_id_out(master_id_out), .handover_out(handover_out),
    .avm_waitrequest_out(avm_waitrequest_out));
`default_nettype wire

// ### verilog/msa_arbiter_top.sv
// Purpose: One processor's copy of the distributed shared bus arbiter
// Assumes: Every processor sees all request lines on the same clock
// Notes: Register port serves local software and remote direct access
// Functional notes
// - Unique id, drive own line, watch all
// - Six request lines, four on module, two exported
// - Select pin high rotating, low fixed
// - Rotating: id above master gets priority one
// - Handover only when master releases, other requests
// - Master keeps bus while its line asserted
// - Release with no requester keeps ownership, no loss
// - Highest priority requester wins next cycle
// - Each copy tracks transitions and new master
// - Handover costs exactly one bus cycle
// - Lock keeps bus through read-modify-write
// - Optional cap on continuous tenure cycles
// - Core-first line lets slave core preempt DMA
// - Broadcast write reaches every processor at once
// - Remote processors reach registers by plain access
// - Eight message registers for remote master
// - Vector register write raises interrupt, gives address
//
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
module msa_arbiter_top #(
    parameter int LINES = msa_pkg::NUM_LINES,
    parameter int TENURE_BITS = msa_pkg::TENURE_W
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [2:0] own_id_in,
    input wire logic rotate_priority_select_in,
    input wire logic [LINES-1:0] bus_request_n_in,
    input wire logic core_first_access_n_in,
    input wire msa_pkg::msa_local_req_t local_req_in,
    input wire logic vector_irq_ack_in,
    input wire msa_pkg::msa_avm_req_t avm_req_in,
    output logic [LINES-1:0] bus_request_n_out,
    output logic [LINES-1:0] bus_request_oe_out,
    output logic core_first_access_n_out,
    output logic core_first_access_oe_out,
    output logic bus_grant_out,
    output logic [2:0] master_id_out,
    output logic handover_out,
    output logic vector_irq_out,
    output logic [msa_pkg::DATA_W-1:0] vector_irq_address_out,
    output logic [msa_pkg::DATA_W-1:0] avm_readdata_out,
    output logic avm_waitrequest_out
);
    import msa_pkg::*;

    localparam logic [2:0] LAST_IDX = 3'(LINES - 1);

    // Next identifier index around the ring of lines
    function automatic logic [2:0] ring_next(input logic [2:0] idx);
        ring_next = (idx == LAST_IDX) ? 3'h0 : 3'(idx + 3'h1);
    endfunction

    // First requester found walking the ring from start
    function automatic logic [2:0] pick_winner(
        input logic [LINES-1:0] req,
        input logic [2:0] start
    );
        logic [2:0] idx;
        logic found;
        idx = start;
        found = 1'b0;
        pick_winner = start;
        for (int i = 0; i < LINES; i++) begin
            if (!found && req[idx]) begin
                pick_winner = idx;
                found = 1'b1;
            end
            idx = ring_next(idx);
        end
    endfunction

    msa_arb_state_t state_ff, nxt_state;
    logic [2:0] master_ff, nxt_master;
    logic [TENURE_BITS-1:0] tenure_cnt_ff;
    logic [TENURE_BITS-1:0] tenure_limit_ff;
    logic [1:0] ctrl_ff;
    logic [1:0] phase_ff;
    logic [DATA_W-1:0] vec_addr_ff;
    logic vec_pend_ff;

    // Own id 1..6 is pin strapped; lines are indexed from zero
    wire logic [2:0] own_idx = 3'(own_id_in - 3'h1);
    wire logic [LINES-1:0] req_act = ~bus_request_n_in;
    wire logic [LINES-1:0] master_bit = LINES'(1) << master_ff;
    wire logic master_req = |(req_act & master_bit);
    wire logic [LINES-1:0] others_req = req_act & ~master_bit;
    wire logic settled = (state_ff == ARB_SETTLED);
    // Master holding its line blocks any change; lone release changes nothing
    wire logic transition =
        settled && !master_req && |others_req;
    wire logic [2:0] prio_start =
        rotate_priority_select_in ? ring_next(master_ff) : 3'h0;
    wire logic [2:0] winner = pick_winner(others_req, prio_start);
    wire logic we_master = settled && (master_ff == own_idx);

    always_comb begin
        nxt_state = state_ff;
        nxt_master = master_ff;
        unique case (state_ff)
            ARB_SETTLED: begin
                if (transition) begin
                    nxt_master = winner;
                    nxt_state = ARB_HANDOVER;
                end
            end
            ARB_HANDOVER: begin
                nxt_state = ARB_SETTLED;
            end
            default: begin
                nxt_state = ARB_SETTLED;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_ff <= ARB_SETTLED;
            master_ff <= INIT_MASTER;
        end else begin
            state_ff <= nxt_state;
            master_ff <= nxt_master;
        end
    end

    // Own request: wanted, unless the master must step aside
    wire logic others_for_us = |(req_act & ~(LINES'(1) << own_idx));
    wire logic want_bus = local_req_in.core_req || local_req_in.dma_req;
    wire logic tenure_over = ctrl_ff[CTRL_TENURE_EN] &&
        (tenure_cnt_ff >= tenure_limit_ff);
    wire logic core_preempt = ctrl_ff[CTRL_CORE_FIRST] &&
        !core_first_access_n_in && !local_req_in.core_req;
    // Lock wins over both yields so a semaphore update is not split
    wire logic must_yield = we_master && others_for_us &&
        !local_req_in.lock && (tenure_over || core_preempt);
    wire logic nxt_own_req = (want_bus || (we_master && local_req_in.lock))
        && !must_yield;
    wire logic nxt_core_first = ctrl_ff[CTRL_CORE_FIRST] && !we_master &&
        local_req_in.core_req && state_ff == ARB_SETTLED;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tenure_cnt_ff <= '0;
        end else if (!we_master || !others_for_us) begin
            tenure_cnt_ff <= '0;
        end else if (!tenure_over) begin
            tenure_cnt_ff <= tenure_cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            bus_request_n_out <= '1;
            bus_request_oe_out <= '0;
            core_first_access_n_out <= 1'b1;
            core_first_access_oe_out <= 1'b0;
            bus_grant_out <= 1'b0;
            master_id_out <= 3'h1;
            handover_out <= 1'b0;
        end else begin
            // Only our own line is ever driven
            bus_request_n_out <= ~(LINES'(nxt_own_req) << own_idx);
            bus_request_oe_out <= LINES'(1) << own_idx;
            core_first_access_n_out <= !nxt_core_first;
            core_first_access_oe_out <= nxt_core_first;
            bus_grant_out <= (nxt_state == ARB_SETTLED) &&
                (nxt_master == own_idx);
            master_id_out <= 3'(nxt_master + 3'h1);
            handover_out <= (nxt_state == ARB_HANDOVER);
        end
    end

    // Register port: target id field selects us, another processor or all
    wire logic [2:0] tgt = avm_req_in.address[TGT_HI:TGT_LO];
    wire logic [3:0] ridx = avm_req_in.address[IDX_HI:IDX_LO];
    wire logic is_bcast = (tgt == TGT_BCAST);
    wire logic for_us = (tgt == own_id_in) || is_bcast;
    wire logic any_req = avm_req_in.read || avm_req_in.write;
    wire logic commit = any_req && !avm_waitrequest_out;
    wire logic wr_ok = commit && avm_req_in.write && for_us;
    wire logic is_msg = ridx[IDX_MSG_BIT];
    wire logic msg_wr = wr_ok && is_msg;
    wire logic vec_wr = wr_ok && ridx == IDX_VECTOR;
    logic [DATA_W-1:0] msg_rdata;
    logic [DATA_W-1:0] reg_rdata;

    msa_msg_ram #(
        .WIDTH(DATA_W),
        .DEPTH(MSG_REGS),
        .AW(3)
    ) u_msg (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .wr_en_in(msg_wr),
        .wr_addr_in(ridx[2:0]),
        .wr_data_in(avm_req_in.writedata),
        .rd_addr_in(ridx[2:0]),
        .rd_data_out(msg_rdata)
    );

    wire logic [DATA_W-1:0] status_word = DATA_W'({
        own_id_in, 2'h0, vec_pend_ff, !settled, we_master,
        3'(master_ff + 3'h1)});

    always_comb begin
        reg_rdata = '0;
        if (tgt == own_id_in) begin
            if (is_msg) begin
                reg_rdata = msg_rdata;
            end else if (ridx == IDX_CTRL) begin
                reg_rdata = DATA_W'(ctrl_ff);
            end else if (ridx == IDX_TENURE) begin
                reg_rdata = DATA_W'(tenure_limit_ff);
            end else if (ridx == IDX_STATUS) begin
                reg_rdata = status_word;
            end else if (ridx == IDX_VECTOR) begin
                reg_rdata = vec_addr_ff;
            end
        end
    end

    // Two cycles of wait let the message store answer from a register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            phase_ff <= 2'h0;
            avm_waitrequest_out <= 1'b1;
            avm_readdata_out <= '0;
        end else begin
            phase_ff <= (any_req && avm_waitrequest_out) ?
                2'(phase_ff + 2'h1) : 2'h0;
            avm_waitrequest_out <=
                !(any_req && avm_waitrequest_out && phase_ff == PH_ISSUE);
            if (any_req && phase_ff == PH_ISSUE) begin
                avm_readdata_out <= reg_rdata;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ctrl_ff <= CTRL_RESET;
            tenure_limit_ff <= TENURE_BITS'(TENURE_RESET);
            vec_addr_ff <= '0;
            vec_pend_ff <= 1'b0;
            vector_irq_out <= 1'b0;
            vector_irq_address_out <= '0;
        end else begin
            if (wr_ok && ridx == IDX_CTRL) begin
                ctrl_ff <= avm_req_in.writedata[1:0];
            end
            if (wr_ok && ridx == IDX_TENURE) begin
                tenure_limit_ff <= avm_req_in.writedata[TENURE_BITS-1:0];
            end
            if (vec_wr) begin
                vec_addr_ff <= avm_req_in.writedata;
            end
            // A new vector arriving with the acknowledge stays pending
            if (vec_wr) begin
                vec_pend_ff <= 1'b1;
            end else if (vector_irq_ack_in) begin
                vec_pend_ff <= 1'b0;
            end
            vector_irq_out <= vec_wr || (vec_pend_ff && !vector_irq_ack_in);
            if (vec_wr) begin
                vector_irq_address_out <= avm_req_in.writedata;
            end
        end
    end
endmodule
`default_nettype wire

// ### verilog/msa_msg_ram.sv
// Purpose: Message register storage with registered read data
// Assumes: One write port, one read port, same clock
// Notes: Read data appear one cycle after the address
`timescale 1ns/10ps
`default_nettype none
module msa_msg_ram #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic [AW-1:0] rd_addr_in,
    output logic [WIDTH-1:0] rd_data_out
);
    logic [WIDTH-1:0] mem_ff [DEPTH];

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_ff[i] <= '0;
            end
            rd_data_out <= '0;
        end else begin
            if (wr_en_in) begin
                mem_ff[wr_addr_in] <= wr_data_in;
            end
            rd_data_out <= mem_ff[rd_addr_in];
        end
    end
endmodule
`default_nettype wire
